// >>> rtl/ahb_pkg.sv
// Purpose: shared constants for the asynchronous host bus interface
// Assumes: 25 MHz core clock
// Notes:   no registers reachable by software
package ahb_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESET_MIN_NS  = 100;
	localparam int RESET_MIN_CYC =
		(RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READY_WAIT_CYC = 2;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	localparam int          ADDR_HI_LSB = 4;
	localparam logic [11:0] IO_BASE_HI  = 12'h030;
	localparam logic [15:0] IO_BASE     = 16'h0300;

	// ------------------------------------------------------------
	// Byte enable patterns, active low
	// ------------------------------------------------------------
	localparam logic [3:0] BE_DWORD = 4'h0;
	localparam logic [3:0] BE_LOW_W = 4'hc;
	localparam logic [3:0] BE_HI_W  = 4'h3;
	localparam logic [3:0] BE_BYTE0 = 4'he;
	localparam logic [3:0] BE_BYTE1 = 4'hd;
	localparam logic [3:0] BE_BYTE2 = 4'hb;
	localparam logic [3:0] BE_BYTE3 = 4'h7;

	// Access size
	typedef enum logic [2:0] {
		SZ_NONE = 3'h0,
		SZ_BYTE = 3'h1,
		SZ_WORD = 3'h2,
		SZ_DWORD = 3'h4
	} ahb_size_t;

	// Bus cycle states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_DONE = 4'h4,
		ST_HOLD = 4'h8
	} ahb_state_t;

endpackage

// >>> rtl/ahb_decode_if.sv
// Purpose: carries the decode result from decoder to bus unit
// Assumes: single clock
// Notes:   combinational decode
`timescale 1ns/100ps
interface ahb_decode_if;
	logic              claim;
	logic              data_sel;
	logic              size_ok;
	logic [3:0]        lane_en;
	ahb_pkg::ahb_size_t size;

	modport dec (output claim, data_sel, size_ok, lane_en, size);
	modport use_(input claim, data_sel, size_ok, lane_en, size);
endinterface

// >>> rtl/ahb_decode.sv
// Purpose: address match and byte enable decode
// Assumes: address latch is handled by the caller
// Notes:   pure combinational
`timescale 1ns/100ps
module ahb_decode (
	// Latched address and qualifiers
	input  wire logic [15:1] addr,
	input  wire logic [3:0]  byte_lane_enables,
	input  wire logic        address_qualifier_low,
	input  wire logic        data_port_select,
	input  wire logic        data_port_addr,
	// Result
	ahb_decode_if.dec        dec
);

	// ------------------------------------------------------------
	// Byte enable decode
	// ------------------------------------------------------------
	function automatic ahb_pkg::ahb_size_t be_size(input logic [3:0] be);
		case (be)
			ahb_pkg::BE_DWORD: be_size = ahb_pkg::SZ_DWORD;
			ahb_pkg::BE_LOW_W,
			ahb_pkg::BE_HI_W:  be_size = ahb_pkg::SZ_WORD;
			ahb_pkg::BE_BYTE0,
			ahb_pkg::BE_BYTE1,
			ahb_pkg::BE_BYTE2,
			ahb_pkg::BE_BYTE3: be_size = ahb_pkg::SZ_BYTE;
			default:           be_size = ahb_pkg::SZ_NONE;
		endcase
	endfunction

	logic hit;
	logic dsel;

	// Claim and size check
	always_comb begin
		hit = !address_qualifier_low && // RULE_08
			(addr[15:4] == ahb_pkg::IO_BASE_HI); // RULE_07
		dsel = !data_port_select ||  // RULE_10
			(hit && data_port_addr);
		dec.size     = be_size(byte_lane_enables); // RULE_15
		dec.data_sel = dsel;
		dec.claim    = (hit || dsel) && (dec.size != ahb_pkg::SZ_NONE);
		dec.size_ok  = dsel || (dec.size != ahb_pkg::SZ_DWORD); // RULE_11
		dec.lane_en  = ~byte_lane_enables; // RULE_05
	end

endmodule // ahb_decode

// >>> rtl/ahb_bus_unit.sv
// Purpose: asynchronous strobe-driven host bus interface unit
// Assumes: strobes treated as synchronous to core_clk
// Notes:   data pins split into in, out and output enable;
//          ready returns on the wait count, not on a host event;
//          claim follows decode alone, strobes do not gate it
//
// How it works
// [RULE_01] Transfers are framed only by read and write strobe edges.
// [RULE_02] Ready drops as soon as a strobe leading edge is seen.
// [RULE_03] Ready is released from the core clock after the wait count.
// [RULE_04] The host keeps the strobe low while ready is low.
// [RULE_05] Byte data moves on the lanes its byte enables select.
// [RULE_06] An 8-bit host uses lane 0 for even, lane 1 for odd addresses.
// [RULE_07] Only addresses whose upper bits equal the base 300h are claimed; a low data port select claims any address.
// [RULE_08] Nothing is claimed unless the address qualifier is low; a low data port select claims with the qualifier high.
// [RULE_09] The address latch strobe is low-active and transparent when low.
// [RULE_10] The data port select reaches the data port without decode.
// [RULE_11] Double-word access is accepted only at the data port.
// [RULE_12] The host never mixes asynchronous and synchronous transfers.
// [RULE_13] Synchronous-only inputs are held inactive by the host.
// [RULE_14] The local device claim goes low on a valid decode.
// [RULE_15] Byte enables decode to dword, word or single byte.
// [RULE_16] Reset held at least 100 ns forces and keeps default state.
// [RULE_17] Only enabled lanes are driven on a claimed read.
`timescale 1ns/100ps
module ahb_bus_unit #(
	parameter int DATA_W   = 32,
	parameter int WAIT_CYC = ahb_pkg::READY_WAIT_CYC,
	parameter logic [3:0] DATA_PORT_OFS = 4'h8
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// Host address and control
	input  wire logic [15:1]       addr,
	input  wire logic [3:0]        byte_lane_enables,
	input  wire logic              address_qualifier_low,
	input  wire logic              address_latch_strobe,
	input  wire logic              host_read_strobe,
	input  wire logic              host_write_strobe,
	input  wire logic              data_port_select,
	// Host data pins
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic      [3:0]        data_oe,
	// Host handshake
	output logic                   async_ready_out,
	output logic                   local_device_claim,
	// Core side
	output logic                   core_wr,
	output logic                   core_rd,
	output logic                   core_data_port,
	output logic      [15:1]       core_addr,
	output logic      [3:0]        core_lanes,
	output logic      [DATA_W-1:0] core_wdata,
	input  wire logic [DATA_W-1:0] core_rdata,
	output logic                   in_reset
);

	// ------------------------------------------------------------
	// Address latch
	// ------------------------------------------------------------
	logic [15:1] lat_addr_r, lat_addr_nxt;
	logic [3:0]  lat_be_r, lat_be_nxt;
	logic        lat_qual_r, lat_qual_nxt;
	logic [15:1] eff_addr;
	logic [3:0]  eff_be;
	logic        eff_qual;

	// Transparent while strobe low, held while high
	always_comb begin
		lat_addr_nxt = lat_addr_r;
		lat_be_nxt   = lat_be_r;
		lat_qual_nxt = lat_qual_r;
		if (!address_latch_strobe) begin // RULE_09
			lat_addr_nxt = addr;
			lat_be_nxt   = byte_lane_enables;
			lat_qual_nxt = address_qualifier_low;
		end
		eff_addr = address_latch_strobe ? lat_addr_r : addr;
		eff_be   = address_latch_strobe ? lat_be_r : byte_lane_enables;
		eff_qual = address_latch_strobe ? lat_qual_r : address_qualifier_low;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			lat_addr_r <= 15'h0000;
			lat_be_r   <= 4'hf;
			lat_qual_r <= 1'b1;
		end else begin
			lat_addr_r <= lat_addr_nxt;
			lat_be_r   <= lat_be_nxt;
			lat_qual_r <= lat_qual_nxt;
		end
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	ahb_decode_if dif ();

	ahb_decode u_dec (
		.addr                  (eff_addr),
		.byte_lane_enables     (eff_be),
		.address_qualifier_low (eff_qual),
		.data_port_select      (data_port_select),
		.data_port_addr        (eff_addr[3:1] == DATA_PORT_OFS[3:1]),
		.dec                   (dif)
	);

	// ------------------------------------------------------------
	// Reset qualification
	// ------------------------------------------------------------
	logic [2:0] rst_cnt_r, rst_cnt_nxt;
	logic       rst_q_r, rst_q_nxt;

	// Reset must stand for the minimum time before in_reset rises
	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		rst_q_nxt   = rst_q_r;
		if (!nrst) begin
			if (rst_cnt_r < 3'(ahb_pkg::RESET_MIN_CYC))
				rst_cnt_nxt = rst_cnt_r + 3'h1;
			else
				rst_q_nxt = 1'b1; // RULE_16
		end else begin
			rst_cnt_nxt = 3'h0;
			rst_q_nxt   = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		rst_cnt_r <= rst_cnt_nxt;
		rst_q_r   <= rst_q_nxt;
	end

	// ------------------------------------------------------------
	// Strobe history
	// ------------------------------------------------------------
	logic        rd_d_r, rd_d_nxt;
	logic        wr_d_r, wr_d_nxt;

	// Falling edge of an active-low strobe
	function automatic logic strobe_fell(input logic prev, input logic now);
		return prev && !now;
	endfunction

	// Last strobe levels; idle high so reset makes no false edge
	always_comb begin
		rd_d_nxt = host_read_strobe;
		wr_d_nxt = host_write_strobe;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_d_r <= 1'b1;
			wr_d_r <= 1'b1;
		end else begin
			rd_d_r <= rd_d_nxt;
			wr_d_r <= wr_d_nxt;
		end
	end

	// ------------------------------------------------------------
	// Strobe tracking and ready
	// ------------------------------------------------------------
	ahb_pkg::ahb_state_t st_r, st_nxt;
	logic [3:0]  wcnt_r, wcnt_nxt;
	logic        rd_fall, wr_fall, strobe_low;
	logic        go;
	logic        rdy_r, rdy_nxt;
	logic        claim_r, claim_nxt;
	logic        crd_r, crd_nxt, cwr_r, cwr_nxt;
	logic        dport_r, dport_nxt;
	logic [3:0]  lanes_r, lanes_nxt;
	logic [15:1] caddr_r, caddr_nxt;
	logic [DATA_W-1:0] wdat_r, wdat_nxt;
	logic [DATA_W-1:0] rdat_r, rdat_nxt;
	logic [3:0]  oe_r, oe_nxt;

	// Cycle state machine
	always_comb begin
		rd_fall    = strobe_fell(rd_d_r, host_read_strobe); // RULE_01
		wr_fall    = strobe_fell(wr_d_r, host_write_strobe); // RULE_01
		strobe_low = !host_read_strobe || !host_write_strobe;
		go         = (rd_fall || wr_fall) && dif.claim && dif.size_ok;
		st_nxt     = st_r;
		wcnt_nxt   = wcnt_r;
		rdy_nxt    = rdy_r;
		crd_nxt    = 1'b0;
		cwr_nxt    = 1'b0;
		dport_nxt  = dport_r;
		lanes_nxt  = lanes_r;
		caddr_nxt  = caddr_r;
		wdat_nxt   = wdat_r;
		rdat_nxt   = rdat_r;
		oe_nxt     = oe_r;
		claim_nxt  = !dif.claim; // RULE_14
		case (st_r)
			ahb_pkg::ST_IDLE: begin
				// Only a claimed, legal access starts a cycle
				oe_nxt = 4'h0;
				if (go) begin
					rdy_nxt   = 1'b0; // RULE_02
					wcnt_nxt  = 4'(WAIT_CYC);
					dport_nxt = dif.data_sel;
					lanes_nxt = dif.lane_en; // RULE_05
					caddr_nxt = eff_addr;
					st_nxt    = ahb_pkg::ST_WAIT;
				end
			end
			ahb_pkg::ST_WAIT: begin
				// Host holds strobe while not ready
				if (wcnt_r != 4'h0) begin // RULE_04
					wcnt_nxt = wcnt_r - 4'h1;
				end else begin
					// Take write data or launch read data
					if (!host_write_strobe) begin
						cwr_nxt  = 1'b1;
						wdat_nxt = data_in;
					end else begin
						crd_nxt  = 1'b1;
						rdat_nxt = core_rdata;
						oe_nxt   = lanes_r; // RULE_17
					end
					st_nxt = ahb_pkg::ST_DONE;
				end
			end
			ahb_pkg::ST_DONE: begin
				// Ready returns on the core clock
				rdy_nxt = 1'b1; // RULE_03
				st_nxt  = ahb_pkg::ST_HOLD;
			end
			ahb_pkg::ST_HOLD: begin
				// Keep read data until the strobe rises
				if (!strobe_low) begin
					oe_nxt = 4'h0; // RULE_17
					st_nxt = ahb_pkg::ST_IDLE;
				end
			end
			default: begin
				st_nxt  = ahb_pkg::ST_IDLE;
				rdy_nxt = 1'b1;
				oe_nxt  = 4'h0;
			end
		endcase
		if (rst_q_r) begin
			st_nxt    = ahb_pkg::ST_IDLE;
			rdy_nxt   = 1'b1;
			oe_nxt    = 4'h0;
			claim_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_r    <= ahb_pkg::ST_IDLE;
			wcnt_r  <= 4'h0;
			rdy_r   <= 1'b1;
			claim_r <= 1'b1;
			crd_r   <= 1'b0;
			cwr_r   <= 1'b0;
			dport_r <= 1'b0;
			lanes_r <= 4'h0;
			caddr_r <= 15'h0000;
			wdat_r  <= '0;
			rdat_r  <= '0;
			oe_r    <= 4'h0;
		end else begin
			st_r    <= st_nxt;
			wcnt_r  <= wcnt_nxt;
			rdy_r   <= rdy_nxt;
			claim_r <= claim_nxt;
			crd_r   <= crd_nxt;
			cwr_r   <= cwr_nxt;
			dport_r <= dport_nxt;
			lanes_r <= lanes_nxt;
			caddr_r <= caddr_nxt;
			wdat_r  <= wdat_nxt;
			rdat_r  <= rdat_nxt;
			oe_r    <= oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	assign async_ready_out    = rdy_r;
	assign local_device_claim = claim_r;
	assign data_out           = rdat_r;
	assign data_oe            = oe_r;
	assign core_wr            = cwr_r;
	assign core_rd            = crd_r;
	assign core_data_port     = dport_r;
	assign core_addr          = caddr_r;
	assign core_lanes         = lanes_r;
	assign core_wdata         = wdat_r;
	assign in_reset           = rst_q_r;

endmodule // ahb_bus_unit

// >>> dv/ahb_bus_unit_properties.sv
// Purpose: timing checks for the host bus unit
// Assumes: wait count left at its default
// Notes:   bound in the bench top file
`timescale 1ns/100ps
module ahb_bus_unit_properties #(
	parameter logic [3:0] DATA_PORT_OFS = 4'h8
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        nrst,
	// Host pins
	input wire logic [15:1] addr,
	input wire logic [3:0]  byte_lane_enables,
	input wire logic        address_qualifier_low,
	input wire logic        data_port_select,
	input wire logic        host_read_strobe,
	input wire logic        host_write_strobe,
	input wire logic [3:0]  data_oe,
	input wire logic        async_ready_out,
	input wire logic        local_device_claim,
	// Core pulses
	input wire logic        core_rd,
	input wire logic        core_wr
);
	logic base;
	logic ok;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Base match and an acceptable access
	assign base = !address_qualifier_low && addr[15:4] == 12'h030;
	assign ok = (base || !data_port_select)
		&& (byte_lane_enables inside {4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7}
		|| (byte_lane_enables == 4'h0
		&& (!data_port_select || addr[3:1] == DATA_PORT_OFS[3:1])));

	AST_READY_HOLD: assert property (
		($fell(host_read_strobe) || $fell(host_write_strobe)) && ok
		|=> !async_ready_out [*4] ##1 async_ready_out
	) else $error("ready not held four cycles");
	AST_RD_PULSE: assert property (
		$fell(host_read_strobe) && ok |-> ##4 core_rd ##1 !core_rd
	) else $error("read pulse misplaced");
	AST_WR_PULSE: assert property (
		$fell(host_write_strobe) && ok |-> ##4 core_wr ##1 !core_wr
	) else $error("write pulse misplaced");
	AST_REFUSE: assert property (
		($fell(host_read_strobe) || $fell(host_write_strobe)) && !ok
		|=> (async_ready_out && data_oe == 4'h0) [*3]
	) else $error("refused access answered");
	AST_NO_CLAIM: assert property (
		address_qualifier_low && data_port_select |=> local_device_claim
	) else $error("claim without qualifier");
	AST_CLAIM: assert property (
		base && ok |=> !local_device_claim
	) else $error("base address not claimed");
	AST_OE_LANES: assert property (
		core_rd |-> data_oe == ~byte_lane_enables
	) else $error("driven lanes differ from enables");
	AST_RESET: assert property (disable iff (1'b0)
		!nrst |=> async_ready_out && local_device_claim && data_oe == 4'h0
	) else $error("outputs not cleared in reset");

	// Main scenarios
	cover property ($fell(host_read_strobe) && ok);
	cover property ($fell(host_write_strobe) && ok);
	cover property ($fell(host_read_strobe) && !ok);
endmodule // ahb_bus_unit_properties

// >>> dv/ahb_host_model.sv
// Purpose: host processor on the asynchronous strobe bus
// Assumes: one strobe cycle at a time, no synchronous traffic
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/100ps
module ahb_host_model (
	// Clock
	input  wire logic        core_clk,
	// Bus to the device
	output logic      [15:1] addr,
	output logic      [3:0]  byte_lane_enables,
	output logic             address_qualifier_low,
	output logic             address_latch_strobe,
	output logic             host_read_strobe,
	output logic             host_write_strobe,
	output logic             data_port_select,
	output logic      [31:0] data_in,
	// Answers
	input  wire logic [31:0] data_out,
	input  wire logic [3:0]  data_oe,
	input  wire logic        async_ready_out
);
	// Idle bus, latch strobe held low
	initial begin
		addr = 15'h0000;
		byte_lane_enables = 4'hf;
		address_qualifier_low = 1'b1;
		address_latch_strobe = 1'b0;
		host_read_strobe = 1'b1;
		host_write_strobe = 1'b1;
		data_port_select = 1'b1;
		data_in = 32'h0;
	end

	// One strobe cycle; took tells if ready was pulled low
	task automatic access(input logic w, input logic [15:1] a,
		input logic [3:0] be, input logic aq, input logic ds,
		input logic [31:0] wd, output logic [31:0] rd,
		output logic [3:0] oe, output logic took);
		int n;
		took = 1'b0;
		n = 0;
		@(posedge core_clk);
		addr <= a;
		byte_lane_enables <= be;
		address_qualifier_low <= aq;
		data_port_select <= ds;
		data_in <= w ? wd : ~data_in;
		host_write_strobe <= !w;
		host_read_strobe <= w;
		// Strobe stays low while ready is low
		do begin
			@(posedge core_clk);
			n++;
			took = took | !async_ready_out;
		end while (!(took && async_ready_out) && n < 12);
		rd = data_out;
		oe = data_oe;
		host_read_strobe <= 1'b1;
		host_write_strobe <= 1'b1;
		address_qualifier_low <= 1'b1;
		data_port_select <= 1'b1;
		byte_lane_enables <= 4'hf;
		data_in <= ~data_in;
		repeat (2) @(posedge core_clk);
	endtask
endmodule // ahb_host_model

// >>> dv/ahb_bus_unit_tb.sv
// Purpose: self-checking bench for the host bus unit
// Assumes: default wait count, 25 MHz core clock
// Notes:   host side played by the host model
`timescale 1ns/100ps
module ahb_bus_unit_tb;
	logic        core_clk, nrst, aq, als, rd_n, wr_n, ds;
	logic        ready, claim, in_reset, core_wr, core_rd, core_dp;
	logic        ev_dp, took;
	logic [15:1] addr, core_addr, ev_addr;
	logic [3:0]  be, data_oe, core_lanes, ev_lanes, oe;
	logic [31:0] data_in, data_out, core_wdata, ev_wdata, rd;
	logic [31:0] core_rdata = 32'ha5c3e1f0;
	int          fail_count = 0, tests_run = 0, ev_n = 0, claim_n = 0;

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	ahb_bus_unit ahb_bus_unit_i (.core_clk(core_clk), .nrst(nrst),
		.addr(addr), .byte_lane_enables(be),
		.address_qualifier_low(aq), .address_latch_strobe(als),
		.host_read_strobe(rd_n), .host_write_strobe(wr_n),
		.data_port_select(ds), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .async_ready_out(ready),
		.local_device_claim(claim), .core_wr(core_wr), .core_rd(core_rd),
		.core_data_port(core_dp), .core_addr(core_addr),
		.core_lanes(core_lanes), .core_wdata(core_wdata),
		.core_rdata(core_rdata), .in_reset(in_reset));
	ahb_host_model ahb_host_model_i (.core_clk(core_clk), .addr(addr),
		.byte_lane_enables(be), .address_qualifier_low(aq),
		.address_latch_strobe(als), .host_read_strobe(rd_n),
		.host_write_strobe(wr_n), .data_port_select(ds),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.async_ready_out(ready));

	// Record core side requests
	always @(posedge core_clk) begin
		if (core_rd || core_wr) begin
			ev_lanes <= core_lanes;
			ev_wdata <= core_wdata;
			ev_addr <= core_addr;
			ev_dp <= core_dp;
			ev_n <= ev_n + 1;
		end
	end

	// Count edges with the claim low during a strobe
	always @(posedge core_clk) begin
		if ((!rd_n || !wr_n) && !claim)
			claim_n <= claim_n + 1;
	end

	task automatic chk(input string name, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [31:0] mask(input logic [3:0] l);
		return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
	endfunction

	task automatic acc(input logic w, input logic [15:1] a,
		input logic [3:0] b, input logic q, s, input logic [31:0] wd);
		ahb_host_model_i.access(w, a, b, q, s, wd, rd, oe, took);
	endtask

	// Every enable code read at the data port
	task automatic test_lanes();
		logic [3:0] c [7] = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7};
		int c0;
		foreach (c[i]) begin
			c0 = claim_n;
			acc(1'b0, 15'h0184, c[i], 1'b0, 1'b1, 32'h0);
			chk("claim", {31'h0, claim_n != c0}, 32'h1);
			chk("oe", {28'h0, oe}, {28'h0, ~c[i]});
			chk("lanes", {28'h0, ev_lanes}, {28'h0, ~c[i]});
			chk("rdata", rd & mask(~c[i]), core_rdata & mask(~c[i]));
		end
	endtask

	// Dword write, then byte traffic of a narrow host
	task automatic test_narrow();
		acc(1'b1, 15'h0184, 4'h0, 1'b0, 1'b1, 32'h8e17c2d4);
		chk("wr_dword", ev_wdata, 32'h8e17c2d4);
		acc(1'b1, 15'h0180, 4'hd, 1'b0, 1'b1, 32'h00005a5a);
		chk("wr_odd", ev_wdata & mask(4'h2), 32'h00005a00);
		chk("wr_odd_addr", {17'h0, ev_addr}, 32'h00000180);
		acc(1'b0, 15'h0180, 4'he, 1'b0, 1'b1, 32'h0);
		chk("rd_even_oe", {28'h0, oe}, 32'h00000001);
	endtask

	// Wrong qualifier, wrong base, dword to a plain register
	task automatic test_refuse();
		logic [15:1] a [3] = '{15'h0184, 15'h0188, 15'h0180};
		logic [3:0] b [3] = '{4'he, 4'he, 4'h0};
		logic q [3] = '{1'b1, 1'b0, 1'b0};
		logic k [3] = '{1'b0, 1'b0, 1'b1};
		int n0;
		int c0;
		foreach (a[i]) begin
			n0 = ev_n;
			c0 = claim_n;
			acc(1'b0, a[i], b[i], q[i], 1'b1, 32'h0);
			chk("ref_claim", {31'h0, claim_n != c0}, {31'h0, k[i]});
			chk("refused", {31'h0, took}, 32'h0);
			chk("no_core", ev_n, n0);
		end
	endtask

	// Data port select bypasses the decode
	task automatic test_dsel();
		acc(1'b0, 15'h0000, 4'h0, 1'b1, 1'b0, 32'h0);
		chk("dsel_took", {31'h0, took}, 32'h1);
		chk("dsel_port", {31'h0, ev_dp}, 32'h1);
		chk("dsel_data", rd, core_rdata);
	endtask

	// Short reset is filtered, a long one holds the default state
	task automatic test_reset();
		nrst <= 1'b0;
		repeat (ahb_pkg::RESET_MIN_CYC - 1) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) begin
			@(posedge core_clk);
			chk("short_rst", {31'h0, in_reset}, 32'h0);
		end
		nrst <= 1'b0;
		repeat (ahb_pkg::RESET_MIN_CYC + 1) @(posedge core_clk);
		chk("rst_early", {31'h0, in_reset}, 32'h0);
		@(posedge core_clk);
		chk("rst_held", {31'h0, in_reset}, 32'h1);
		chk("rst_claim", {31'h0, claim}, 32'h1);
		chk("rst_oe", {28'h0, data_oe}, 32'h0);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("rst_gone", {31'h0, in_reset}, 32'h0);
		acc(1'b0, 15'h0184, 4'h0, 1'b0, 1'b1, 32'h0);
		chk("rst_took", {31'h0, took}, 32'h1);
		chk("rst_rdata", rd, core_rdata);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		repeat (16) @(posedge core_clk);
		chk("in_reset", {31'h0, in_reset}, 32'h1);
		chk("rst_ready", {31'h0, ready}, 32'h1);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		test_lanes();
		test_narrow();
		test_refuse();
		test_dsel();
		test_reset();
		stop_test();
	end

	// Watchdog
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule // ahb_bus_unit_tb

bind ahb_bus_unit ahb_bus_unit_properties #(
	.DATA_PORT_OFS(DATA_PORT_OFS)) ahb_bus_unit_properties_i (
	.core_clk(core_clk), .nrst(nrst), .addr(addr),
	.byte_lane_enables(byte_lane_enables),
	.address_qualifier_low(address_qualifier_low),
	.data_port_select(data_port_select),
	.host_read_strobe(host_read_strobe),
	.host_write_strobe(host_write_strobe), .data_oe(data_oe),
	.async_ready_out(async_ready_out),
	.local_device_claim(local_device_claim),
	.core_rd(core_rd), .core_wr(core_wr));
